// ==== analog_comparator_ctrl.v ====
// control and status logic around the analog comparator
// assumes raw comparator output is asynchronous; wishbone classic slave
`timescale 1ns/1ps
`default_nettype none
`include "cmp_defs.vh"
module analog_comparator_ctrl (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        stop2_active,
  // wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // analog side
  input  wire        comparator_raw,
  output wire        bandgap_select,
  output wire        analog_enable,
  output wire        pins_digital_free,
  // routing and pins
  input  wire        background_debug_enable,
  output wire        capture_channel_zero,
  output wire        timer_two_channel_zero_pin_block,
  output wire        comparator_output_pin_o,
  output wire        comparator_output_pin_oe,
  output wire        bus_clock_gate,
  output wire        compare_irq
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg        module_enable_q;
  reg        bandgap_select_q;
  reg        compare_event_flag_q;
  reg        compare_interrupt_enable_q;
  reg        output_pin_enable_q;
  reg  [1:0] flag_edge_mode_q;
  reg        capture_route_q;
  reg        clock_gate_q;
  reg        out_q;
  wire       sync_out;
  wire       event_pulse;
  wire       local_rst;
  wire       run_ce;
  wire       wr;
  wire       rd_hit;
  wire [7:0] ctrl_rd;

  // [RQ11] stop2 power-down acts as a reset
  assign local_rst = rst | stop2_active;
  // [RQ12] no halt input: debug halt never freezes logic
  assign run_ce = ce & clock_gate_q;

  // ----------------------------------------
  // comparator output path
  // ----------------------------------------
  // [RQ21] two-stage sync
  sync_two u_sync (
    .clk (clk),
    .rst (local_rst),
    .ce  (run_ce),
    .d   (comparator_raw & module_enable_q),
    .q   (sync_out)
  );

  // [RQ16] edge selection
  edge_sel u_edge (
    .clk         (clk),
    .rst         (local_rst),
    .ce          (run_ce),
    .arm         (module_enable_q),
    .lvl         (sync_out),
    .mode        (flag_edge_mode_q),
    .event_pulse (event_pulse)
  );

  // [RQ20] status register, zero while disabled
  always @(posedge clk or posedge local_rst) begin
    if (local_rst) begin
      out_q <= 1'b0;
    end else if (run_ce) begin
      out_q <= module_enable_q & sync_out;
    end
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // ack follows ce, not the gated clock, so a gated block still acks every access
  assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign rd_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ctrl_rd = {module_enable_q, bandgap_select_q,
                    compare_event_flag_q, compare_interrupt_enable_q,
                    out_q, output_pin_enable_q, flag_edge_mode_q};

  always @(posedge clk or posedge local_rst) begin
    if (local_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= rd_hit;
      if (rd_hit) begin
        case (wb_adr_i)
          `ADDR_STATUS_CONTROL: wb_dat_o <= {24'h00_0000, ctrl_rd};
          `ADDR_SYSTEM_OPTIONS: wb_dat_o <= {31'h0000_0000, capture_route_q};
          `ADDR_CLOCK_GATING:   wb_dat_o <= {31'h0000_0000, clock_gate_q};
          default:              wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // control state
  // ----------------------------------------
  // [RQ10] every bit returns to reset on any reset
  always @(posedge clk or posedge local_rst) begin
    if (local_rst) begin
      module_enable_q            <= 1'b0;
      bandgap_select_q           <= 1'b0;
      compare_interrupt_enable_q <= 1'b0;
      output_pin_enable_q        <= 1'b0;
      flag_edge_mode_q           <= 2'h0;
      capture_route_q            <= 1'b0;
    end else if (ce) begin
      if (wr && wb_adr_i == `ADDR_STATUS_CONTROL && clock_gate_q) begin
        module_enable_q            <= wb_dat_i[`BIT_MODULE_ENABLE];
        bandgap_select_q           <= wb_dat_i[`BIT_BANDGAP_SELECT];
        compare_interrupt_enable_q <= wb_dat_i[`BIT_INT_ENABLE];
        output_pin_enable_q        <= wb_dat_i[`BIT_OUT_PIN_ENABLE];
        flag_edge_mode_q           <= wb_dat_i[1:0];
      end
      if (wr && wb_adr_i == `ADDR_SYSTEM_OPTIONS) begin
        capture_route_q <= wb_dat_i[`BIT_CAPTURE_ROUTE];
      end
    end
  end

  // [RQ5] gate set by reset, software clears to stop clock
  always @(posedge clk or posedge local_rst) begin
    if (local_rst) begin
      clock_gate_q <= `RESET_CLOCK_GATE;
    end else if (ce && wr && wb_adr_i == `ADDR_CLOCK_GATING) begin
      clock_gate_q <= wb_dat_i[`BIT_CLOCK_GATE];
    end
  end

  // [RQ18] set wins over write-one clear
  always @(posedge clk or posedge local_rst) begin
    if (local_rst) begin
      compare_event_flag_q <= 1'b0;
    end else if (run_ce) begin
      // [RQ9] events keep setting the flag in stop3 and wait
      if (event_pulse) begin
        compare_event_flag_q <= 1'b1;
      end else if (wr && wb_adr_i == `ADDR_STATUS_CONTROL &&
                   wb_dat_i[`BIT_EVENT_FLAG]) begin
        compare_event_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // [RQ19] interrupt, also wake source in wait and stop3
  // [RQ7] wake in wait via irq
  assign compare_irq = compare_interrupt_enable_q & compare_event_flag_q;
  // [RQ15] bandgap select zero picks positive pin
  assign bandgap_select = bandgap_select_q;
  assign analog_enable  = module_enable_q;
  // [RQ14] pins free while disabled
  assign pins_digital_free = ~module_enable_q;
  // [RQ3] capture routing
  assign capture_channel_zero = capture_route_q & out_q;
  // [RQ4] pin detached while routed
  assign timer_two_channel_zero_pin_block = capture_route_q;
  // [RQ8] output pin drive, also in stop3
  // [RQ13] debug pin function takes precedence
  assign comparator_output_pin_oe = output_pin_enable_q & module_enable_q &
                                    ~background_debug_enable;
  assign comparator_output_pin_o  = out_q;
  assign bus_clock_gate = clock_gate_q;
endmodule // analog_comparator_ctrl
`default_nettype wire

// ==== analog_comparator_ctrl_sva.sv ====
// port checker for the comparator control block
// assumes one clock; bound onto the top module below
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_ctrl_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic stop2_active,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic analog_enable,
  input wire logic pins_digital_free,
  input wire logic background_debug_enable,
  input wire logic capture_channel_zero,
  input wire logic timer_two_channel_zero_pin_block,
  input wire logic comparator_output_pin_o,
  input wire logic comparator_output_pin_oe,
  input wire logic bus_clock_gate,
  input wire logic compare_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o && ce; endsequence
  sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
  AST_ACK: assert property (req_s |=> ack_s)
    else $error("ack not a single pulse");
  AST_GATE_RST: assert property ($past(rst) |-> bus_clock_gate)
    else $error("clock gate not set by reset");
  AST_STOP2: assert property (stop2_active |=>
    !analog_enable && bus_clock_gate && !compare_irq &&
    !timer_two_channel_zero_pin_block) else $error("stop2 not reset");
  AST_FREE: assert property (pins_digital_free == !analog_enable)
    else $error("pin release wrong");
  AST_OE_DBG: assert property (
    background_debug_enable |-> !comparator_output_pin_oe)
    else $error("drive on debug pin");
  AST_OE_EN: assert property (comparator_output_pin_oe |-> analog_enable)
    else $error("drive while disabled");
  AST_CAP: assert property (capture_channel_zero ==
    (timer_two_channel_zero_pin_block && comparator_output_pin_o))
    else $error("capture route wrong");
  AST_OFF: assert property (!analog_enable [*3] |->
    !comparator_output_pin_o) else $error("output while disabled");
endmodule // analog_comparator_ctrl_sva
bind analog_comparator_ctrl analog_comparator_ctrl_sva i_sva (.clk(clk),
  .rst(rst), .ce(ce), .stop2_active(stop2_active), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .analog_enable(analog_enable),
  .pins_digital_free(pins_digital_free),
  .background_debug_enable(background_debug_enable),
  .capture_channel_zero(capture_channel_zero),
  .timer_two_channel_zero_pin_block(timer_two_channel_zero_pin_block),
  .comparator_output_pin_o(comparator_output_pin_o),
  .comparator_output_pin_oe(comparator_output_pin_oe),
  .bus_clock_gate(bus_clock_gate), .compare_irq(compare_irq));
`default_nettype wire

// ==== cmp_defs.vh ====
// constants for the comparator control block
// assumes a classic wishbone slave with 32-bit data, word addressed by byte
// Behaviour
// [RQ1] software enables bandgap buffer before selecting bandgap
// [RQ2] no bandgap select in low power run/wait
// [RQ3] route comparator output to timer capture zero
// [RQ4] routing disconnects timer channel zero pin
// [RQ5] clock gate set by reset, clear stops
// [RQ6] software keeps clock gate set while used
// [RQ7] wait mode operates, interrupt wakes processor
// [RQ8] stop3 keeps comparing and driving output pin
// [RQ9] stop3 event sets flag, wakes if enabled
// [RQ10] reset exit from stop resets all bits
// [RQ11] stop2 powers down, wakes in reset
// [RQ12] background debug mode keeps operating
// [RQ13] no output drive on enabled debug pin
// [RQ14] disabled comparator frees pins for digital use
// [RQ15] bandgap select zero picks positive pin
// [RQ16] software picks rising, falling or both edges
// [RQ17] mode 00/10 fall, 01 rise, 11 both
// [RQ18] flag set by event, write one clears
// [RQ19] interrupt equals enable and flag
// [RQ20] output status live, zero when disabled
// [RQ21] two flip-flop sync before edge detect
`ifndef CMP_DEFS_VH
`define CMP_DEFS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_STATUS_CONTROL 8'h00
`define ADDR_SYSTEM_OPTIONS 8'h04
`define ADDR_CLOCK_GATING   8'h08
// ----------------------------------------
// status and control fields
// ----------------------------------------
`define BIT_MODULE_ENABLE  7
`define BIT_BANDGAP_SELECT 6
`define BIT_EVENT_FLAG     5
`define BIT_INT_ENABLE     4
`define BIT_OUTPUT_STATUS  3
`define BIT_OUT_PIN_ENABLE 2
`define MODE_FALL_A        2'h0
`define MODE_RISE          2'h1
`define MODE_FALL_B        2'h2
`define MODE_BOTH          2'h3
// ----------------------------------------
// other fields and reset values
// ----------------------------------------
`define BIT_CAPTURE_ROUTE  0
`define BIT_CLOCK_GATE     0
`define RESET_CONTROL      8'h00
`define RESET_CLOCK_GATE   1'b1
`endif

// ==== comparator_front.sv ====
// far-side model: the comparator itself, fed by two pins and a reference
// assumes integer levels driven by the bench; raw result is unclocked while enabled
`timescale 1ns/1ps
`default_nettype none
module comparator_front (
  input  wire logic clk,
  input  wire logic en,
  input  wire logic bgs,
  input  var  int   pos,
  input  var  int   neg,
  input  var  int   bg,
  output wire logic raw
);
  logic t = 1'b0;
  // off: a pattern, never a held level
  always @(posedge clk) t <= ~t;
  assign raw = en ? ((bgs ? bg : pos) > neg) : t;
endmodule // comparator_front
`default_nettype wire

// ==== edge_sel.v ====
// selected-edge event detector on a synchronised level
// assumes lvl already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "cmp_defs.vh"
module edge_sel (
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire       arm,
  input  wire       lvl,
  input  wire [1:0] mode,
  output wire       event_pulse
);
  reg prev_q;
  reg hit;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= lvl;
    end
  end
  // [RQ17] mode decode
  always @* begin
    case (mode)
      `MODE_RISE: hit = lvl & ~prev_q;
      `MODE_BOTH: hit = lvl ^ prev_q;
      default:    hit = ~lvl & prev_q;
    endcase
  end
  assign event_pulse = arm & hit;
endmodule // edge_sel
`default_nettype wire

// ==== sync_two.v ====
// two flip-flop level synchroniser
// assumes input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module sync_two (
  input  wire clk,
  input  wire rst,
  input  wire ce,
  input  wire d,
  output wire q
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule // sync_two
`default_nettype wire

// ==== test_analog_comparator_ctrl.sv ====
// self-checking bench for the comparator control block
// assumes the far-side model and the bound checker are compiled before
`timescale 1ns/1ps
`default_nettype none
`include "cmp_defs.vh"
module test_analog_comparator_ctrl;
  logic clk = 0, rst = 1, ce = 1, s2 = 0, cyc = 0, we = 0, dbg = 0;
  logic [7:0] adr = 0, c;
  logic [31:0] wdat = 0, rd, seed = 32'h8b96_97ad;
  logic b, lvl, nv, fl;
  wire [31:0] dat_o;
  wire ack, raw, bgs, aen, free, cap, tblk, po, poe, gate, irq;
  int pos = 0, neg = 0, bg = 0, n_errors = 0, total_checks = 0, m, j, d;
  analog_comparator_ctrl i_dut (.clk(clk), .rst(rst), .ce(ce),
    .stop2_active(s2), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .comparator_raw(raw), .bandgap_select(bgs),
    .analog_enable(aen), .pins_digital_free(free),
    .background_debug_enable(dbg), .capture_channel_zero(cap),
    .timer_two_channel_zero_pin_block(tblk),
    .comparator_output_pin_o(po), .comparator_output_pin_oe(poe),
    .bus_clock_gate(gate), .compare_irq(irq));
  comparator_front i_fe (.clk(clk), .en(aen), .bgs(bgs), .pos(pos),
    .neg(neg), .bg(bg), .raw(raw));
  initial forever #2 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int i = 0;
    @(posedge clk);
    cyc <= 1; we <= w; adr <= a; wdat <= v;
    do begin @(posedge clk); i++; end while (ack !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_errors++;
      conclude();
    end else begin
      rd = dat_o;
      cyc <= 0;
      we <= 0;
    end
  endtask
  task automatic rchk();
    for (int k = 0; k < 4; k++) begin
      wb(0, 8'(4 * k), 0);
      chk("reset value", 32'(k == 2), rd);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    rchk();
    for (m = 0; m < 4; m++) begin
      b = (m == 3);
      pos <= 0; neg <= 1; bg <= 0; lvl = 0; fl = 0;
      c = 8'h90 | 8'(b) << 6 | 8'(m);
      wb(1, 8'h00, c);
      repeat (8) @(posedge clk);
      wb(1, 8'h00, c | 8'h20);
      for (j = 0; j < 6; j++) begin
        seed = xs(seed);
        nv = seed[7:0] > seed[15:8];
        neg <= seed[15:8];
        if (b) bg <= seed[7:0];
        else pos <= seed[7:0];
        if (nv != lvl && (m == 3 || nv == (m == 1))) fl = 1;
        lvl = nv;
        repeat (6) @(posedge clk);
        wb(0, 8'h00, 0);
        chk("status", c | 8'(fl) << 5 | 8'(lvl) << 3, rd);
        chk("irq", fl, irq);
        chk("bandgap select", b, bgs);
        chk("enable", 1, aen);
        chk("pins free", 0, free);
        wb(1, 8'h00, j[0] ? c | 8'h20 : c);
        if (j[0]) fl = 0;
      end
    end
    wb(1, 8'h00, 8'h04);
    repeat (8) @(posedge clk);
    wb(0, 8'h00, 0);
    chk("disabled", 32'h04, rd);
    chk("pins free off", 1, free);
    chk("irq off", 0, irq);
    pos <= 5; neg <= 1;
    wb(1, 8'h00, 8'h84);
    repeat (8) @(posedge clk);
    for (d = 0; d < 2; d++) begin
      dbg <= d[0];
      repeat (2) @(posedge clk);
      chk("pin enable", !d[0], poe);
      chk("pin", 1, po);
    end
    chk("capture off", 0, cap);
    wb(1, `ADDR_SYSTEM_OPTIONS, 1);
    chk("timer pin", 1, tblk);
    chk("capture", 1, cap);
    wb(1, `ADDR_CLOCK_GATING, 0);
    chk("gate", 0, gate);
    wb(1, 8'h00, 8'h10);
    wb(0, 8'h00, 0);
    chk("gated ctrl", 32'h8c, rd);
    s2 <= 1;
    repeat (2) @(posedge clk);
    s2 <= 0;
    rchk();
    // leave state behind so the mid-run reset has work to do
    wb(1, 8'h00, 8'h84);
    wb(1, `ADDR_SYSTEM_OPTIONS, 1);
    chk("route before reset", 1, tblk);
    chk("enable before reset", 1, aen);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    rchk();
    conclude();
  end
endmodule // test_analog_comparator_ctrl
`default_nettype wire
